// [hw/aux_dma_channel.sv]
// Purpose: Auxiliary DMA channel moving one host word to or from memory.
// Assumes: Memory answers a held mem_req with a one-cycle mem_ack.
// Notes:   Owns the memory clock enable used in the light idle states.

`timescale 1ns/1ps
`default_nettype none

module aux_dma_channel #(
	parameter int DATA_W = host_port_pkg::DATA_W,
	parameter int ADDR_W = host_port_pkg::ADDR_W
) (
	input  wire logic              clk,
	input  wire logic              nrst,
	dma_req_if.channel             acc,
	input  wire logic              idle_state_one,
	input  wire logic              idle_state_two,
	input  wire logic              idle_state_three,
	output logic                   mem_req,
	output logic                   mem_we,
	output logic [ADDR_W-1:0]      mem_addr,
	output logic [DATA_W-1:0]      mem_wdata,
	input  wire logic              mem_ack,
	input  wire logic [DATA_W-1:0] mem_rdata,
	output logic                   mem_clk_en
);

	typedef enum logic [1:0] {
		CH_IDLE  = 2'b00,
		CH_CLKON = 2'b01,
		CH_REQ   = 2'b11,
		CH_DONE  = 2'b10
	} ch_state_type;

	ch_state_type      state_ff, nxt_state;
	logic              pend_ff, nxt_pend;
	logic              req_ff, nxt_req;
	logic              we_ff, nxt_we;
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic [DATA_W-1:0] wdata_ff, nxt_wdata;
	logic [DATA_W-1:0] rdata_ff, nxt_rdata;
	logic              done_ff, nxt_done;
	logic              clk_en_ff, nxt_clk_en;
	logic              light_idle;

	assign light_idle = idle_state_one | idle_state_two;

	always_comb begin
		nxt_state  = state_ff;
		nxt_pend   = pend_ff;
		nxt_req    = req_ff;
		nxt_we     = we_ff;
		nxt_addr   = addr_ff;
		nxt_wdata  = wdata_ff;
		nxt_rdata  = rdata_ff;
		nxt_done   = 1'b0;
		if (acc.req) begin
			nxt_pend  = 1'b1;
			nxt_we    = acc.we;
			nxt_addr  = acc.addr;
			nxt_wdata = acc.wdata;
		end
		case (state_ff)
			CH_IDLE: begin
				// Deep idle stops every clock, so the access waits
				if (pend_ff && !idle_state_three) begin
					nxt_state = CH_CLKON;
				end
			end
			CH_CLKON: begin
				// One cycle for the gated clock to come up
				nxt_state = CH_REQ;
				nxt_req   = 1'b1;
			end
			CH_REQ: begin
				if (mem_ack) begin
					nxt_req   = 1'b0;
					nxt_rdata = mem_rdata;
					nxt_state = CH_DONE;
				end
			end
			CH_DONE: begin
				nxt_pend  = 1'b0;
				nxt_done  = 1'b1;
				nxt_state = CH_IDLE;
			end
			default: begin
				nxt_state = CH_IDLE;
				nxt_req   = 1'b0;
			end
		endcase
		// Clocks on per access only while the CPU sleeps lightly
		nxt_clk_en = !(light_idle || idle_state_three) ||
			     (nxt_state != CH_IDLE);
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_ff  <= CH_IDLE;
			pend_ff   <= 1'b0;
			req_ff    <= 1'b0;
			we_ff     <= 1'b0;
			addr_ff   <= host_port_pkg::ADDR_RST;
			wdata_ff  <= host_port_pkg::DATA_RST;
			rdata_ff  <= host_port_pkg::DATA_RST;
			done_ff   <= 1'b0;
			clk_en_ff <= 1'b1;
		end else begin
			state_ff  <= nxt_state;
			pend_ff   <= nxt_pend;
			req_ff    <= nxt_req;
			we_ff     <= nxt_we;
			addr_ff   <= nxt_addr;
			wdata_ff  <= nxt_wdata;
			rdata_ff  <= nxt_rdata;
			done_ff   <= nxt_done;
			clk_en_ff <= nxt_clk_en;
		end
	end

	// No I/O space strobe exists: only program/data memory is driven
	assign mem_req    = req_ff;
	assign mem_we     = we_ff;
	assign mem_addr   = addr_ff;
	assign mem_wdata  = wdata_ff;
	assign mem_clk_en = clk_en_ff;
	assign acc.done   = done_ff;
	assign acc.rdata  = rdata_ff;

endmodule

`default_nettype wire

// [hw/dma_req_if.sv]
// Purpose: Carries one access between port logic and its DMA channel.
// Assumes: req and done are one-cycle pulses, one access in flight.
// Notes:   rdata is valid from done onward until the next req.

`timescale 1ns/1ps
`default_nettype none

interface dma_req_if #(
	parameter int DATA_W = host_port_pkg::DATA_W,
	parameter int ADDR_W = host_port_pkg::ADDR_W
);
	logic              req;
	logic              we;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              done;
	logic [DATA_W-1:0] rdata;

	modport port    (output req, output we, output addr, output wdata,
			 input done, input rdata);
	modport channel (input req, input we, input addr, input wdata,
			 output done, output rdata);
endinterface

`default_nettype wire

// [hw/host_memory_access_port.sv]
// Purpose: Slave host port giving a 16-bit host reach into on-chip memory.
// Assumes: Host pins are synchronous to clk; memory answers via mem_ack.
// Notes:   Every memory access goes through the auxiliary DMA channel.

`timescale 1ns/1ps
`default_nettype none

module host_memory_access_port #(
	parameter int DATA_W = host_port_pkg::DATA_W,
	parameter int ADDR_W = host_port_pkg::ADDR_W
) (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              port_reset_in_n,
	input  wire logic              host_mux_select,
	input  wire logic              host_chip_select_n,
	input  wire logic              host_data_strobe_one_n,
	input  wire logic              host_data_strobe_two_n,
	input  wire logic              host_read_write,
	input  wire logic [1:0]        host_register_select,
	input  wire logic              host_address_strobe_n,
	input  wire logic [ADDR_W-1:0] host_address_bus,
	input  wire logic [DATA_W-1:0] host_data_in,
	output logic      [DATA_W-1:0] host_data_out,
	output logic                   host_data_oe,
	output logic                   host_ready_out,
	output logic                   dsp_to_host_irq_n,
	input  wire logic              dsp_ctrl_wr,
	input  wire logic [DATA_W-1:0] dsp_ctrl_wdata,
	output logic      [DATA_W-1:0] dsp_ctrl_rdata,
	output logic                   host_to_dsp_irq,
	output logic                   dsp_wake_req,
	input  wire logic              idle_state_one,
	input  wire logic              idle_state_two,
	input  wire logic              idle_state_three,
	output logic                   mem_req,
	output logic                   mem_we,
	output logic      [ADDR_W-1:0] mem_addr,
	output logic      [DATA_W-1:0] mem_wdata,
	input  wire logic              mem_ack,
	input  wire logic [DATA_W-1:0] mem_rdata,
	output logic                   mem_clk_en
);

	localparam int PAGE_W = ADDR_W - DATA_W;
	localparam int HOST_TO_DSP_IRQ_BIT = host_port_pkg::CTRL_HOST_TO_DSP_IRQ_BIT_BIT;
	localparam int DSP_TO_HOST_IRQ   = host_port_pkg::CTRL_DSP_TO_HOST_IRQ_BIT;
	localparam int PREF   = host_port_pkg::CTRL_PREFETCH_BIT;
	localparam int PG     = host_port_pkg::CTRL_PAGE_LSB;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_HOLD = 2'b11
	} acc_state_type;

	// ****************************************
	// Reset: the port pin frees the port while the core stays in reset
	// ****************************************
	logic port_nrst;
	logic core_run;

	assign port_nrst = nrst | port_reset_in_n;
	assign core_run  = nrst;

	// ****************************************
	// Host strobe decode
	// ****************************************
	logic acc_active;
	logic acc_start;
	logic act_prev_ff, nxt_act_prev;
	logic seen_as_ff, nxt_seen_as;
	logic [1:0] sel_as_ff, nxt_sel_as;
	logic rw_as_ff, nxt_rw_as;
	logic [1:0] sel_eff;
	logic rw_eff;

	// Both strobes and the select open an access
	assign acc_active = !host_chip_select_n && !host_data_strobe_one_n &&
			    !host_data_strobe_two_n;
	assign acc_start  = acc_active && !act_prev_ff;
	// Address strobe latches select and direction for muxed hosts
	assign sel_eff = seen_as_ff ? sel_as_ff : host_register_select;
	assign rw_eff  = seen_as_ff ? rw_as_ff : host_read_write;

	always_comb begin
		nxt_act_prev = acc_active;
		nxt_seen_as  = seen_as_ff;
		nxt_sel_as   = sel_as_ff;
		nxt_rw_as    = rw_as_ff;
		if (!host_address_strobe_n && !host_mux_select && !acc_active) begin
			nxt_seen_as = 1'b1;
			nxt_sel_as  = host_register_select;
			nxt_rw_as   = host_read_write;
		end else if (acc_start) begin
			nxt_seen_as = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!port_nrst) begin
			act_prev_ff <= 1'b0;
			seen_as_ff  <= 1'b0;
			sel_as_ff   <= host_port_pkg::SEL_CTRL;
			rw_as_ff    <= 1'b1;
		end else begin
			act_prev_ff <= nxt_act_prev;
			seen_as_ff  <= nxt_seen_as;
			sel_as_ff   <= nxt_sel_as;
			rw_as_ff    <= nxt_rw_as;
		end
	end

	// ****************************************
	// Access sequencer
	// ****************************************
	dma_req_if #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) dma ();

	acc_state_type     state_ff, nxt_state;
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic              pref_en_ff, nxt_pref_en;
	logic              dsp_to_host_irq_ff, nxt_dsp_to_host_irq;
	logic              pf_valid_ff, nxt_pf_valid;
	logic [DATA_W-1:0] pf_data_ff, nxt_pf_data;
	logic              is_pf_ff, nxt_is_pf;
	logic              rd_ff, nxt_rd;
	logic              inc_ff, nxt_inc;
	logic [DATA_W-1:0] dout_ff, nxt_dout;
	logic              oe_ff, nxt_oe;
	logic              rdy_ff, nxt_rdy;
	logic              irq_ff, nxt_irq, irq_n_ff, nxt_irq_n;
	logic              wake_ff, nxt_wake;
	logic              dreq_ff, nxt_dreq;
	logic              dwe_ff, nxt_dwe;
	logic [ADDR_W-1:0] daddr_ff, nxt_daddr;
	logic [DATA_W-1:0] dwdata_ff, nxt_dwdata;
	logic [DATA_W-1:0] dsp_rd_ff, nxt_dsp_rd;
	logic [DATA_W-1:0] ctrl_word;
	logic              host_ctrl_wr;
	logic              dsp_to_host_irq_set;
	logic              dsp_to_host_irq_clr;
	logic              any_idle;

	always_comb begin
		ctrl_word = '0;
		ctrl_word[DSP_TO_HOST_IRQ] = dsp_to_host_irq_ff;
		ctrl_word[PREF] = pref_en_ff;
		ctrl_word[PG +: PAGE_W] = addr_ff[ADDR_W-1 -: PAGE_W];
		// The host-to-DSP bit is never stored
		ctrl_word[HOST_TO_DSP_IRQ_BIT] = 1'b0;
	end

	// Control register only exists on the multiplexed bus
	assign host_ctrl_wr = acc_start && !host_mux_select && !rw_eff &&
			      (sel_eff == host_port_pkg::SEL_CTRL);
	// Zero writes neither set nor clear; a DSP set beats a host clear
	assign dsp_to_host_irq_set = core_run && dsp_ctrl_wr && dsp_ctrl_wdata[DSP_TO_HOST_IRQ];
	assign dsp_to_host_irq_clr = host_ctrl_wr && host_data_in[DSP_TO_HOST_IRQ];
	assign any_idle = idle_state_one | idle_state_two | idle_state_three;

	always_comb begin
		nxt_state    = state_ff;
		nxt_addr     = addr_ff;
		nxt_pref_en  = pref_en_ff;
		nxt_pf_valid = pf_valid_ff;
		nxt_pf_data  = pf_data_ff;
		nxt_is_pf    = is_pf_ff;
		nxt_rd       = rd_ff;
		nxt_inc      = inc_ff;
		nxt_dout     = dout_ff;
		nxt_rdy      = rdy_ff;
		nxt_irq      = 1'b0;
		nxt_wake     = 1'b0;
		nxt_dreq     = 1'b0;
		nxt_dwe      = dwe_ff;
		nxt_daddr    = daddr_ff;
		nxt_dwdata   = dwdata_ff;
		nxt_dsp_to_host_irq     = dsp_to_host_irq_set ? 1'b1 : (dsp_to_host_irq_clr ? 1'b0 : dsp_to_host_irq_ff);
		nxt_irq_n    = !nxt_dsp_to_host_irq;
		nxt_dsp_rd   = ctrl_word;
		case (state_ff)
			ST_IDLE: begin
				nxt_rdy = 1'b1;
				if (acc_start && host_mux_select) begin
					// Separate buses: full 18-bit address, always DMA
					nxt_rd     = host_read_write;
					nxt_inc    = 1'b0;
					nxt_is_pf  = 1'b0;
					nxt_dreq   = 1'b1;
					nxt_dwe    = !host_read_write;
					nxt_daddr  = host_address_bus;
					nxt_dwdata = host_data_in;
					nxt_rdy    = 1'b0;
					nxt_state  = ST_WAIT;
				end else if (acc_start) begin
					nxt_rd    = rw_eff;
					nxt_inc   = (sel_eff == host_port_pkg::SEL_DATA_INC);
					nxt_is_pf = 1'b0;
					nxt_state = ST_HOLD;
					case (sel_eff)
						host_port_pkg::SEL_CTRL: begin
							if (rw_eff) begin
								nxt_dout = ctrl_word;
							end else begin
								nxt_pref_en = host_data_in[PREF];
								nxt_addr[ADDR_W-1 -: PAGE_W] =
									host_data_in[PG +: PAGE_W];
								nxt_pf_valid = 1'b0;
								if (host_data_in[HOST_TO_DSP_IRQ_BIT]) begin
									nxt_irq  = 1'b1;
									nxt_wake = any_idle;
								end
							end
						end
						host_port_pkg::SEL_ADDR: begin
							if (rw_eff) begin
								nxt_dout = addr_ff[DATA_W-1:0];
							end else begin
								nxt_addr[DATA_W-1:0] = host_data_in;
								nxt_pf_valid = 1'b0;
								// Prefetch hides the read latency of the next data read
								if (pref_en_ff) begin
									nxt_is_pf = 1'b1;
									nxt_dreq  = 1'b1;
									nxt_dwe   = 1'b0;
									nxt_daddr = {addr_ff[ADDR_W-1 -: PAGE_W],
										     host_data_in};
									nxt_rdy   = 1'b0;
									nxt_state = ST_WAIT;
								end
							end
						end
						default: begin
							if (rw_eff && pf_valid_ff) begin
								nxt_dout     = pf_data_ff;
								nxt_pf_valid = 1'b0;
								if (nxt_inc) begin
									nxt_addr = addr_ff + 1'b1;
								end
							end else begin
								nxt_pf_valid = 1'b0;
								nxt_dreq     = 1'b1;
								nxt_dwe      = !rw_eff;
								nxt_daddr    = addr_ff;
								nxt_dwdata   = host_data_in;
								nxt_rdy      = 1'b0;
								nxt_state    = ST_WAIT;
							end
						end
					endcase
				end
			end
			ST_WAIT: begin
				// CPU halt does not stop the channel
				if (dma.done) begin
					if (is_pf_ff) begin
						nxt_pf_data  = dma.rdata;
						nxt_pf_valid = 1'b1;
					end else begin
						if (rd_ff) begin
							nxt_dout = dma.rdata;
						end
						if (inc_ff) begin
							nxt_addr = addr_ff + 1'b1;
						end
					end
					nxt_rdy   = 1'b1;
					nxt_state = acc_active ? ST_HOLD : ST_IDLE;
				end
			end
			ST_HOLD: begin
				nxt_rdy = 1'b1;
				if (!acc_active) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_rdy   = 1'b1;
			end
		endcase
		// Drive the bus only for a read that is ready and still strobed
		nxt_oe = acc_active && nxt_rd && nxt_rdy && !nxt_is_pf &&
			 (nxt_state != ST_IDLE);
	end

	always_ff @(posedge clk) begin
		if (!port_nrst) begin
			state_ff    <= ST_IDLE;
			addr_ff     <= host_port_pkg::ADDR_RST;
			pref_en_ff  <= 1'b0;
			dsp_to_host_irq_ff     <= 1'b0;
			pf_valid_ff <= 1'b0;
			pf_data_ff  <= host_port_pkg::DATA_RST;
			is_pf_ff    <= 1'b0;
			rd_ff       <= 1'b0;
			inc_ff      <= 1'b0;
			dout_ff     <= host_port_pkg::DATA_RST;
			oe_ff       <= 1'b0;
			rdy_ff      <= 1'b1;
			irq_ff      <= 1'b0;
			irq_n_ff    <= 1'b1;
			wake_ff     <= 1'b0;
			dreq_ff     <= 1'b0;
			dwe_ff      <= 1'b0;
			daddr_ff    <= host_port_pkg::ADDR_RST;
			dwdata_ff   <= host_port_pkg::DATA_RST;
			dsp_rd_ff   <= host_port_pkg::DATA_RST;
		end else begin
			state_ff    <= nxt_state;
			addr_ff     <= nxt_addr;
			pref_en_ff  <= nxt_pref_en;
			dsp_to_host_irq_ff     <= nxt_dsp_to_host_irq;
			pf_valid_ff <= nxt_pf_valid;
			pf_data_ff  <= nxt_pf_data;
			is_pf_ff    <= nxt_is_pf;
			rd_ff       <= nxt_rd;
			inc_ff      <= nxt_inc;
			dout_ff     <= nxt_dout;
			oe_ff       <= nxt_oe;
			rdy_ff      <= nxt_rdy;
			irq_ff      <= nxt_irq;
			irq_n_ff    <= nxt_irq_n;
			wake_ff     <= nxt_wake;
			dreq_ff     <= nxt_dreq;
			dwe_ff      <= nxt_dwe;
			daddr_ff    <= nxt_daddr;
			dwdata_ff   <= nxt_dwdata;
			dsp_rd_ff   <= nxt_dsp_rd;
		end
	end

	assign dma.req    = dreq_ff;
	assign dma.we     = dwe_ff;
	assign dma.addr   = daddr_ff;
	assign dma.wdata  = dwdata_ff;

	// ****************************************
	// Auxiliary DMA channel
	// ****************************************
	aux_dma_channel #(
		.DATA_W(DATA_W),
		.ADDR_W(ADDR_W)
	) u_chan (
		.clk              (clk),
		.nrst             (port_nrst),
		.acc              (dma),
		.idle_state_one   (idle_state_one),
		.idle_state_two   (idle_state_two),
		.idle_state_three (idle_state_three),
		.mem_req          (mem_req),
		.mem_we           (mem_we),
		.mem_addr         (mem_addr),
		.mem_wdata        (mem_wdata),
		.mem_ack          (mem_ack),
		.mem_rdata        (mem_rdata),
		.mem_clk_en       (mem_clk_en)
	);

	// Mode pin level selects the bus decode above
	assign host_data_out     = dout_ff;
	assign host_data_oe      = oe_ff;
	assign host_ready_out    = rdy_ff;
	assign dsp_to_host_irq_n = irq_n_ff;
	assign host_to_dsp_irq   = irq_ff;
	assign dsp_wake_req      = wake_ff;
	assign dsp_ctrl_rdata    = dsp_rd_ff;

endmodule

`default_nettype wire

// [hw/host_port_pkg.sv]
// Purpose: Shared constants for the host memory access port.
// Assumes: 16-bit host data, 18-bit on-chip word address.
// Notes:   Control word layout and register select codes live here.

package host_port_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int DATA_W = 16;
	localparam int ADDR_W = 18;
	localparam int PAGE_W = ADDR_W - DATA_W;

	// ****************************************
	// Register select codes, multiplexed mode
	// ****************************************
	localparam logic [1:0] SEL_CTRL     = 2'h0;
	localparam logic [1:0] SEL_DATA_INC = 2'h1;
	localparam logic [1:0] SEL_ADDR     = 2'h2;
	localparam logic [1:0] SEL_DATA     = 2'h3;

	// ****************************************
	// Control word bit positions
	// ****************************************
	localparam int CTRL_HOST_TO_DSP_IRQ_BIT_BIT   = 1;
	localparam int CTRL_DSP_TO_HOST_IRQ_BIT     = 2;
	localparam int CTRL_PREFETCH_BIT = 3;
	localparam int CTRL_PAGE_LSB     = 4;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam logic [17:0] ADDR_RST = 18'h00000;
	localparam logic [1:0]  PAGE_RST = 2'h0;

endpackage

// [tb/host_memory_access_port_chk.sv]
// Purpose: Port-level properties of the host memory access port.
// Assumes: One clock; the port resets only with both resets low.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module host_memory_access_port_chk #(
	parameter int DATA_W = host_port_pkg::DATA_W,
	parameter int ADDR_W = host_port_pkg::ADDR_W
) (
	input wire logic              clk,
	input wire logic              nrst,
	input wire logic              port_reset_in_n,
	input wire logic              host_mux_select,
	input wire logic              host_chip_select_n,
	input wire logic              host_data_strobe_one_n,
	input wire logic              host_data_strobe_two_n,
	input wire logic              host_read_write,
	input wire logic [1:0]        host_register_select,
	input wire logic [DATA_W-1:0] host_data_in,
	input wire logic              host_ready_out,
	input wire logic              dsp_to_host_irq_n,
	input wire logic              dsp_ctrl_wr,
	input wire logic [DATA_W-1:0] dsp_ctrl_wdata,
	input wire logic [DATA_W-1:0] dsp_ctrl_rdata,
	input wire logic              host_to_dsp_irq,
	input wire logic              dsp_wake_req,
	input wire logic              idle_state_one,
	input wire logic              idle_state_two,
	input wire logic              idle_state_three,
	input wire logic              mem_req,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic              mem_ack,
	input wire logic              mem_clk_en
);
	logic act, act_ff, st, cw, idl;
	assign act = !host_chip_select_n && !host_data_strobe_one_n
		&& !host_data_strobe_two_n;
	always_ff @(posedge clk) act_ff <= act;
	assign st = act && !act_ff;
	assign idl = idle_state_one || idle_state_two || idle_state_three;
	// Host control write in multiplexed mode
	assign cw = st && !host_mux_select && !host_read_write
		&& host_register_select == host_port_pkg::SEL_CTRL;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst && !port_reset_in_n);

	a_irq_pin_set: assert property (
		nrst && dsp_ctrl_wr && dsp_ctrl_wdata[2] |=> !dsp_to_host_irq_n)
		else $error("host interrupt pin not raised");
	a_zero_no_effect: assert property (
		nrst && dsp_ctrl_wr && !dsp_ctrl_wdata[2] && host_chip_select_n
		|=> $stable(dsp_to_host_irq_n))
		else $error("zero write moved host interrupt");
	a_host_clear: assert property (
		cw && host_data_in[2] && !dsp_ctrl_wr ##1 !dsp_ctrl_wr
		|-> dsp_to_host_irq_n)
		else $error("host acknowledge did not clear");
	a_dsp_int_pulse: assert property (
		cw && host_data_in[1] |=> host_to_dsp_irq)
		else $error("no interrupt to core");
	a_wake_idle: assert property (
		dsp_wake_req == (host_to_dsp_irq && $past(idl)))
		else $error("wake request wrong");
	a_int_bit_zero: assert property (
		dsp_ctrl_rdata[1] == 1'b0)
		else $error("interrupt bit reads one");
	a_ready_dma: assert property (
		st && host_mux_select |=> !host_ready_out)
		else $error("ready not dropped for access");
	a_dma_starts: assert property (
		st && host_mux_select && !idle_state_three |-> ##[2:8] mem_req)
		else $error("access started no memory cycle");
	a_req_hold: assert property (
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("memory request dropped early");
	a_req_clk_on: assert property (
		mem_req |-> mem_clk_en)
		else $error("memory clock off during request");

	c_nonmux: cover property (st && host_mux_select);
	c_wake: cover property (dsp_wake_req);
	c_irq_clear: cover property ($rose(dsp_to_host_irq_n));
endmodule

bind host_memory_access_port host_memory_access_port_chk #(
	.DATA_W(DATA_W), .ADDR_W(ADDR_W)) chk_u (
	.clk, .nrst, .port_reset_in_n, .host_mux_select,
	.host_chip_select_n, .host_data_strobe_one_n,
	.host_data_strobe_two_n, .host_read_write, .host_register_select,
	.host_data_in, .host_ready_out, .dsp_to_host_irq_n, .dsp_ctrl_wr,
	.dsp_ctrl_wdata, .dsp_ctrl_rdata, .host_to_dsp_irq, .dsp_wake_req,
	.idle_state_one, .idle_state_two, .idle_state_three, .mem_req,
	.mem_addr, .mem_ack, .mem_clk_en);
`default_nettype wire

// [tb/host_memory_access_port_tb.sv]
// Purpose: Self-checking bench for the host memory access port.
// Assumes: Memory model answers after a random latency.
// Notes:   Address strobe latches select and rw before strobes.
`timescale 1ns/1ps
`default_nettype none
module host_memory_access_port_tb;
	logic        clk, nrst, port_reset_in_n, host_mux_select;
	logic        host_chip_select_n, host_data_strobe_one_n;
	logic        host_data_strobe_two_n, host_read_write, dsp_ctrl_wr;
	logic        idle_state_one, idle_state_two, idle_state_three;
	logic        host_data_oe, host_ready_out, dsp_to_host_irq_n;
	logic        host_to_dsp_irq, dsp_wake_req, mem_req, mem_we;
	logic        mem_ack, mem_clk_en, host_address_strobe_n;
	logic [1:0]  host_register_select;
	logic [2:0]  lat;
	logic [15:0] host_data_in, host_data_out, dsp_ctrl_wdata;
	logic [15:0] dsp_ctrl_rdata, mem_wdata, mem_rdata, q, w;
	logic [17:0] host_address_bus, mem_addr, a;
	logic [31:0] rng;
	logic [15:0] expm [int];
	int          bad_count, n_compared, n_irq, n_wake, i;

	host_memory_access_port dut_u (.clk, .nrst, .port_reset_in_n,
		.host_mux_select, .host_chip_select_n, .host_data_strobe_one_n,
		.host_data_strobe_two_n, .host_read_write, .host_register_select,
		.host_address_strobe_n, .host_address_bus, .host_data_in,
		.host_data_out, .host_data_oe, .host_ready_out, .dsp_to_host_irq_n,
		.dsp_ctrl_wr, .dsp_ctrl_wdata, .dsp_ctrl_rdata, .host_to_dsp_irq,
		.dsp_wake_req, .idle_state_one, .idle_state_two, .idle_state_three,
		.mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
		.mem_clk_en);
	mem_model mem_u (.clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .lat,
		.mem_ack, .mem_rdata);

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [15:0] cword(input logic [1:0] pg,
		input logic di, input logic hc);
		return {10'h000, pg, 1'b0, hc, di, 1'b0};
	endfunction

	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Host cycle: strobes held until ready is seen
	task automatic acc(input logic nm, input logic [1:0] s, input logic rd,
		input logic [17:0] ad, input logic [15:0] d);
		int k;
		rng = xs(rng);
		host_register_select <= nm ? rng[11:10] : s;
		host_read_write <= rd;
		host_address_strobe_n <= nm;
		@(posedge clk);
		lat <= rng[2:0];
		if (nm)
			{idle_state_two, idle_state_one} <= rng[9:8];
		host_mux_select <= nm;
		host_address_bus <= nm ? ad : rng[29:12];
		host_data_in <= rd ? rng[31:16] : d;
		host_chip_select_n <= 1'b0;
		host_data_strobe_one_n <= 1'b0;
		host_data_strobe_two_n <= 1'b0;
		repeat (2) @(posedge clk);
		for (k = 0; k < 80 && host_ready_out !== 1'b1; k++)
			@(posedge clk);
		q = host_data_out;
		chk({16'h0, host_ready_out, host_data_oe}, {17'h1, rd});
		host_chip_select_n <= 1'b1;
		host_data_strobe_one_n <= 1'b1;
		host_data_strobe_two_n <= 1'b1;
	endtask
	task automatic dsp(input logic [15:0] d);
		@(posedge clk);
		dsp_ctrl_wr <= 1'b1;
		dsp_ctrl_wdata <= d;
		@(posedge clk);
		dsp_ctrl_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rw_pair(input logic [17:0] ad);
		rng = xs(rng);
		w = rng[31:16];
		acc(1'b1, 2'h0, 1'b0, ad, w);
		expm[ad] = w;
		acc(1'b1, 2'h0, 1'b1, ad, 16'h0000);
		chk({2'h0, q}, {2'h0, w});
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge clk) begin
		if (host_to_dsp_irq === 1'b1)
			n_irq++;
		if (dsp_wake_req === 1'b1)
			n_wake++;
	end
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Watchdog: far beyond the longest expected run
	initial begin
		#200000;
		bad_count++;
		results();
	end

	initial begin
		{nrst, port_reset_in_n, dsp_ctrl_wr, host_read_write} = 4'h1;
		{host_chip_select_n, host_data_strobe_one_n} = 2'h3;
		{host_data_strobe_two_n, host_mux_select} = 2'h3;
		{idle_state_one, idle_state_two, idle_state_three} = 3'h0;
		host_register_select = 2'h0;
		host_address_strobe_n = 1'b1;
		host_address_bus = 18'h00000;
		{host_data_in, dsp_ctrl_wdata} = 32'h0;
		lat = 3'h0;
		rng = 32575;
		{bad_count, n_compared, n_irq, n_wake} = '0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		port_reset_in_n <= 1'b1;
		for (i = 0; i < 16; i++) begin
			a = {i[1:0], 16'(xs(rng + i))};
			rw_pair(i == 15 ? 18'h3FFFF : a);
		end
		nrst <= 1'b0;
		rw_pair(18'h2ABCD);
		nrst <= 1'b1;
		idle_state_one <= 1'b1;
		idle_state_two <= 1'b0;
		repeat (4) @(posedge clk);
		chk({17'h0, mem_clk_en}, 18'h0);
		idle_state_one <= 1'b0;
		// Multiplexed: page, address, autoincrement across a page edge
		acc(1'b0, host_port_pkg::SEL_CTRL, 1'b0, 0, cword(2'h1, 1, 0));
		acc(1'b0, host_port_pkg::SEL_CTRL, 1'b1, 0, 16'h0000);
		chk({2'h0, q}, {2'h0, cword(2'h1, 0, 0)});
		acc(1'b0, host_port_pkg::SEL_ADDR, 1'b0, 0, 16'hFFFE);
		for (i = 0; i < 3; i++) begin
			w = 16'(xs(rng + i));
			acc(1'b0, host_port_pkg::SEL_DATA_INC, 1'b0, 0, w);
			expm[18'h1FFFE + i] = w;
		end
		acc(1'b0, host_port_pkg::SEL_ADDR, 1'b1, 0, 16'h0000);
		chk({2'h0, q}, 18'h00001);
		for (i = 0; i < 3; i++) begin
			acc(1'b1, 2'h0, 1'b1, 18'h1FFFE + i, 16'h0000);
			chk({2'h0, q}, {2'h0, expm[18'h1FFFE + i]});
		end
		acc(1'b0, host_port_pkg::SEL_CTRL, 1'b0, 0, 16'h0018);
		acc(1'b0, host_port_pkg::SEL_ADDR, 1'b0, 0, 16'hFFFE);
		acc(1'b0, host_port_pkg::SEL_DATA, 1'b1, 0, 16'h0000);
		chk({2'h0, q}, {2'h0, expm[18'h1FFFE]});
		for (i = 0; i < 3; i++) begin
			acc(1'b0, host_port_pkg::SEL_DATA_INC, 1'b1, 0, 16'h0000);
			chk({2'h0, q}, {2'h0, expm[18'h1FFFE + i]});
		end
		// Interrupts both ways
		dsp(16'h0004);
		chk({17'h0, dsp_to_host_irq_n}, 18'h0);
		dsp(16'hFFFB);
		chk({17'h0, dsp_to_host_irq_n}, 18'h0);
		acc(1'b1, 2'h0, 1'b0, 18'h00100, 16'h0004);
		chk({17'h0, dsp_to_host_irq_n}, 18'h0);
		acc(1'b0, host_port_pkg::SEL_CTRL, 1'b0, 0, 16'h0000);
		chk({17'h0, dsp_to_host_irq_n}, 18'h0);
		acc(1'b0, host_port_pkg::SEL_CTRL, 1'b0, 0, 16'h0004);
		chk({17'h0, dsp_to_host_irq_n}, 18'h1);
		idle_state_three <= 1'b1;
		acc(1'b0, host_port_pkg::SEL_CTRL, 1'b0, 0, 16'h0002);
		repeat (2) @(posedge clk);
		idle_state_three <= 1'b0;
		chk(n_irq[17:0], 18'h2);
		chk(n_wake[17:0], 18'h1);
		results();
	end
endmodule
`default_nettype wire

// [tb/mem_model.sv]
// Purpose: On-chip memory seen from the auxiliary channel.
// Assumes: A held request is answered after lat extra cycles.
// Notes:   Read data is scrambled every cycle outside a read answer.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
	input  wire logic        clk,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [17:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	input  wire logic [2:0]  lat,
	output logic             mem_ack,
	output logic      [15:0] mem_rdata
);
	logic [15:0] m [int];
	int          cnt;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 16'h0000;
		cnt = 0;
	end
	// Program and data words over all four pages
	always @(posedge clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack) begin
			if (cnt >= lat) begin
				cnt <= 0;
				mem_ack <= 1'b1;
				if (mem_we)
					m[mem_addr] = mem_wdata;
				else
					mem_rdata <= m.exists(mem_addr) ?
						m[mem_addr] : ~mem_addr[15:0];
			end else
				cnt <= cnt + 1;
		end
	end
endmodule
`default_nettype wire
